// file: inc/tsx_map.vh
// Function
// - Host port selected only while chip select low
// - Access only while strobe and select both low
// - Read/write sets data bus direction
// - 16-bit address reaches every internal memory
// - Bidirectional 16-bit host data bus
// - Acknowledge marks completion; host waits for it
// - Cycle end: drive acknowledge high, then release
// - Frame pulse format detected automatically
// - Frame evaluation timed against frame pulse
// - Gate low and standby low: outputs high-Z, bar upper pins in indicator mode
// - Gate high enables serial output drivers
// - Per-channel connection bit forces high-Z, bar upper pins in indicator mode
// - Reset clears registers but not memories, floats outputs and bus
// - 32 serial inputs and 32 outputs
// - Any input channel reaches any output channel
// - Per-channel variable or constant delay
// - Per-stream programmable input bit offset
// - 512 channels per frame, equal rates
// - Indicator mode: upper pins show stream status
// - Processor mode sends low byte every frame
`ifndef TSX_MAP_VH
`define TSX_MAP_VH

// Stream geometry
`define TSX_NUM_STREAMS 32
`define TSX_CH_PER_FRAME 512

// Host address regions, bits 15:14
`define TSX_RGN_DATA 2'h0
`define TSX_RGN_CONN 2'h1
`define TSX_RGN_MODE 2'h2
`define TSX_RGN_REGS 2'h3

// Register indices inside the register region
`define TSX_REG_CTRL 5'h00
`define TSX_REG_MEAS 5'h01
`define TSX_REG_FMT 5'h02
`define TSX_REG_OFS_BIT 5

// Control register fields and reset value
`define TSX_CTRL_STBY 0
`define TSX_CTRL_OEI 1
`define TSX_CTRL_RST 16'h0000

// Connection entry fields
`define TSX_CM_HIZ 15
`define TSX_CM_PROC 14

// Ticks of steady level before the idle frame level is learned
`define TSX_IDLE_RUN 3'h4

// Timing
`define TSX_CLK_PERIOD_NS 40
`define TSX_RST_HOLD_NS 20
`define TSX_RST_HOLD_CYC ((`TSX_RST_HOLD_NS + `TSX_CLK_PERIOD_NS - 1) / `TSX_CLK_PERIOD_NS)

// Host port states
`define TSX_HS_IDLE 2'h0
`define TSX_HS_ACK 2'h1
`define TSX_HS_REL 2'h2

`endif

// file: core/tsx_core.v
`include "tsx_map.vh"
`default_nettype none

module tsx_core (
	input wire core_clk,
	input wire rst_b,
	input wire serial_bit_clock_in,
	input wire frame_sync_in,
	input wire frame_eval_in,
	input wire output_drive_gate,
	input wire host_cs_b,
	input wire host_strobe_n,
	input wire host_rd_wr,
	input wire [15:0] host_addr_bus,
	input wire [15:0] host_data_bus_i,
	output reg [15:0] host_data_bus_o,
	output reg host_data_bus_oe_b,
	output reg host_transfer_ack_o,
	output reg host_transfer_ack_oe_b,
	input wire [31:0] serial_in_streams,
	output reg [31:0] serial_out_streams_o,
	output reg [31:0] serial_out_streams_oe_b
);

	// Data memory, two frame banks: {bank, stream, channel}
	reg [7:0] dmem [0:32767];
	// Connection memory: {hiz, proc, source stream, source channel}
	reg [15:0] cmem [0:16383];
	// Per-channel delay mode, 1 = constant delay
	reg dmode [0:16383];

	reg [2:0] ofs_r [0:31];
	reg [6:0] in_sh_r [0:31];
	reg [7:0] out_sh_r [0:31];
	reg [31:0] ch_hiz_r;
	reg [15:0] ctrl_r;
	reg [11:0] bit_cnt_r;
	reg frame_par_r;
	reg bclk_prev_r;
	reg fs_prev_r;
	reg idle_lvl_r;
	reg fmt_valid_r;
	reg [2:0] run_cnt_r;
	reg fe_prev_r;
	reg [11:0] meas_cnt_r;
	reg [11:0] meas_r;
	reg [1:0] hst_r;
	reg [15:0] rd_data;

	wire tick;
	wire pulse_start;
	wire slot_end;
	wire glob_en;
	wire host_sel;
	wire host_wr;
	wire [1:0] rgn;
	wire [8:0] nch;
	wire [31:0] in_wr_w;
	wire [447:0] wr_idx_w;
	wire [255:0] nbyte_w;
	wire [31:0] nhiz_w;

	integer i;

	// Bit clock sampled as a level, rising edge marks one bit time
	assign tick = serial_bit_clock_in & ~bclk_prev_r;
	assign slot_end = tick & (bit_cnt_r[2:0] == 3'h7);
	assign nch = bit_cnt_r[11:3] + 9'h001;
	// Frame pulse is the level opposite to the learned idle level
	assign pulse_start = tick & fmt_valid_r & (frame_sync_in != idle_lvl_r)
		& (fs_prev_r == idle_lvl_r);
	// Standby bit keeps drivers on even with the gate low
	assign glob_en = output_drive_gate | ctrl_r[`TSX_CTRL_STBY];
	assign host_sel = ~host_cs_b & ~host_strobe_n;
	assign host_wr = (hst_r == `TSX_HS_IDLE) & host_sel & ~host_rd_wr;
	assign rgn = host_addr_bus[15:14];

	// Per-stream input alignment and output byte fetch
	genvar s;
	generate
		for (s = 0; s < `TSX_NUM_STREAMS; s = s + 1) begin : g_strm
			localparam [4:0] SID = s;
			wire [11:0] loc;
			wire [15:0] cm;
			wire use_prev;
			// Input sampling window shifted by the stream offset
			assign loc = bit_cnt_r - {9'h000, ofs_r[s]};
			assign in_wr_w[s] = tick & (loc[2:0] == 3'h7);
			assign wr_idx_w[s*14 +: 14] = {SID, loc[11:3]};
			// Entry for the slot about to start on this output
			assign cm = cmem[{SID, nch}];
			// Constant delay always takes last frame; variable takes newest
			assign use_prev = dmode[{SID, nch}] | (cm[8:0] >= nch);
			assign nbyte_w[s*8 +: 8] = cm[`TSX_CM_PROC] ? cm[7:0] :
				dmem[{frame_par_r ^ use_prev, cm[13:0]}];
			assign nhiz_w[s] = cm[`TSX_CM_HIZ];
		end
	endgenerate

	// Host read data mux
	always @* begin
		rd_data = 16'h0000;
		if (rgn == `TSX_RGN_DATA) begin
			rd_data = {8'h00, dmem[{frame_par_r, host_addr_bus[13:0]}]};
		end else if (rgn == `TSX_RGN_CONN) begin
			rd_data = cmem[host_addr_bus[13:0]];
		end else if (rgn == `TSX_RGN_MODE) begin
			rd_data = {15'h0000, dmode[host_addr_bus[13:0]]};
		end else if (host_addr_bus[`TSX_REG_OFS_BIT]) begin
			rd_data = {13'h0000, ofs_r[host_addr_bus[4:0]]};
		end else if (host_addr_bus[4:0] == `TSX_REG_CTRL) begin
			rd_data = ctrl_r;
		end else if (host_addr_bus[4:0] == `TSX_REG_MEAS) begin
			rd_data = {4'h0, meas_r};
		end else if (host_addr_bus[4:0] == `TSX_REG_FMT) begin
			rd_data = {14'h0000, fmt_valid_r, ~idle_lvl_r};
		end
	end

	// Memories: serial capture and host writes, no reset
	always @(posedge core_clk) begin
		for (i = 0; i < `TSX_NUM_STREAMS; i = i + 1) begin
			if (in_wr_w[i]) begin
				dmem[{frame_par_r, wr_idx_w[i*14 +: 14]}] <= {in_sh_r[i], serial_in_streams[i]};
			end
		end
		if (host_wr && rgn == `TSX_RGN_CONN) begin
			cmem[host_addr_bus[13:0]] <= host_data_bus_i;
		end
		if (host_wr && rgn == `TSX_RGN_MODE) begin
			dmode[host_addr_bus[13:0]] <= host_data_bus_i[0];
		end
	end

	// Frame timing, format detection and delay measurement
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			bclk_prev_r <= 1'b0;
			bit_cnt_r <= 12'h000;
			frame_par_r <= 1'b0;
			fs_prev_r <= 1'b0;
			idle_lvl_r <= 1'b0;
			fmt_valid_r <= 1'b0;
			run_cnt_r <= 3'h0;
			fe_prev_r <= 1'b0;
			meas_cnt_r <= 12'h000;
			meas_r <= 12'h000;
		end else begin
			bclk_prev_r <= serial_bit_clock_in;
			if (tick) begin
				fs_prev_r <= frame_sync_in;
				fe_prev_r <= frame_eval_in;
				// Learn the idle level from a long steady run
				if (frame_sync_in != fs_prev_r) begin
					run_cnt_r <= 3'h0;
				end else if (run_cnt_r != `TSX_IDLE_RUN) begin
					run_cnt_r <= run_cnt_r + 3'h1;
				end else begin
					idle_lvl_r <= frame_sync_in;
					fmt_valid_r <= 1'b1;
				end
			end
			// Frame pulse realigns bit count and flips the bank
			if (pulse_start) begin
				bit_cnt_r <= 12'h000;
				frame_par_r <= ~frame_par_r;
				meas_cnt_r <= 12'h000;
			end else if (tick) begin
				bit_cnt_r <= bit_cnt_r + 12'h001;
				meas_cnt_r <= meas_cnt_r + 12'h001;
			end
			// Latch bit distance to the evaluation edge
			if (tick & frame_eval_in & ~fe_prev_r) begin
				meas_r <= meas_cnt_r;
			end
		end
	end

	// Control and offset registers
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_r <= `TSX_CTRL_RST;
			for (i = 0; i < `TSX_NUM_STREAMS; i = i + 1) begin
				ofs_r[i] <= 3'h0;
			end
		end else if (host_wr && rgn == `TSX_RGN_REGS) begin
			if (host_addr_bus[`TSX_REG_OFS_BIT]) begin
				ofs_r[host_addr_bus[4:0]] <= host_data_bus_i[2:0];
			end else if (host_addr_bus[4:0] == `TSX_REG_CTRL) begin
				ctrl_r <= host_data_bus_i;
			end
		end
	end

	// Serial shifters and output pins
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ch_hiz_r <= 32'hffff_ffff;
			serial_out_streams_o <= 32'h0000_0000;
			serial_out_streams_oe_b <= 32'hffff_ffff;
			for (i = 0; i < `TSX_NUM_STREAMS; i = i + 1) begin
				in_sh_r[i] <= 7'h00;
				out_sh_r[i] <= 8'h00;
			end
		end else begin
			for (i = 0; i < `TSX_NUM_STREAMS; i = i + 1) begin
				if (tick) begin
					in_sh_r[i] <= {in_sh_r[i][5:0], serial_in_streams[i]};
				end
				// Load the next slot MSB first, else shift
				if (slot_end) begin
					out_sh_r[i] <= nbyte_w[i*8 +: 8];
					ch_hiz_r[i] <= nhiz_w[i];
				end else if (tick) begin
					out_sh_r[i] <= {out_sh_r[i][6:0], 1'b0};
				end
				// Upper pins report lower streams in indicator mode
				if (i >= 16 && ctrl_r[`TSX_CTRL_OEI]) begin
					serial_out_streams_o[i] <= glob_en & ~ch_hiz_r[i-16];
					serial_out_streams_oe_b[i] <= 1'b0;
				end else begin
					serial_out_streams_o[i] <= out_sh_r[i][7];
					serial_out_streams_oe_b[i] <= ~(glob_en & ~ch_hiz_r[i]);
				end
			end
		end
	end

	// Host handshake: ack low, drive high at end, then release
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			hst_r <= `TSX_HS_IDLE;
			host_data_bus_o <= 16'h0000;
			host_data_bus_oe_b <= 1'b1;
			host_transfer_ack_o <= 1'b1;
			host_transfer_ack_oe_b <= 1'b1;
		end else begin
			case (hst_r)
				`TSX_HS_IDLE: begin
					if (host_sel) begin
						host_data_bus_o <= rd_data;
						host_data_bus_oe_b <= ~host_rd_wr;
						host_transfer_ack_o <= 1'b0;
						host_transfer_ack_oe_b <= 1'b0;
						hst_r <= `TSX_HS_ACK;
					end
				end
				`TSX_HS_ACK: begin
					if (!host_sel) begin
						host_data_bus_oe_b <= 1'b1;
						host_transfer_ack_o <= 1'b1;
						hst_r <= `TSX_HS_REL;
					end
				end
				`TSX_HS_REL: begin
					host_transfer_ack_oe_b <= 1'b1;
					hst_r <= `TSX_HS_IDLE;
				end
				default: begin
					hst_r <= `TSX_HS_IDLE;
				end
			endcase
		end
	end

endmodule // tsx_core

`default_nettype wire

// file: verification/tsx_checker.sv
`default_nettype none
module tsx_checker (
	input wire core_clk,
	input wire rst_b,
	input wire host_cs_b,
	input wire host_strobe_n,
	input wire host_rd_wr,
	input wire host_data_bus_oe_b,
	input wire host_transfer_ack_o,
	input wire host_transfer_ack_oe_b,
	input wire [31:0] serial_out_streams_oe_b
);
	timeunit 1ns;
	timeprecision 1ns;
	// Selected access and acknowledged state
	wire sel = !host_cs_b && !host_strobe_n;
	wire acked = !host_transfer_ack_o && !host_transfer_ack_oe_b;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	a_take_ack: assert property (sel && host_transfer_ack_oe_b |=> acked)
		else $error("no ack after take");
	a_data_dir: assert property (sel && host_transfer_ack_oe_b |=>
		host_data_bus_oe_b == !$past(host_rd_wr))
		else $error("data bus direction wrong");
	a_ack_holds: assert property (acked && sel |=> acked)
		else $error("ack dropped early");
	a_ack_high: assert property (acked && !sel |=>
		host_transfer_ack_o && !host_transfer_ack_oe_b ##1 host_transfer_ack_oe_b)
		else $error("ack not driven high then released");
	a_bus_float: assert property (acked && !sel |=> host_data_bus_oe_b)
		else $error("data bus still driven");
	a_no_take: assert property (host_transfer_ack_oe_b && !sel |=> host_transfer_ack_oe_b)
		else $error("ack without select");
	a_rel_order: assert property ($rose(host_transfer_ack_oe_b) |-> $past(host_transfer_ack_o))
		else $error("ack released low");
	a_reset_float: assert property (disable iff (1'h0) !rst_b |->
		&serial_out_streams_oe_b && host_data_bus_oe_b && host_transfer_ack_oe_b)
		else $error("pins driven in reset");
endmodule // tsx_checker
bind tsx_core tsx_checker u_chk (.core_clk(core_clk), .rst_b(rst_b), .host_cs_b(host_cs_b),
	.host_strobe_n(host_strobe_n), .host_rd_wr(host_rd_wr),
	.host_data_bus_oe_b(host_data_bus_oe_b), .host_transfer_ack_o(host_transfer_ack_o),
	.host_transfer_ack_oe_b(host_transfer_ack_oe_b),
	.serial_out_streams_oe_b(serial_out_streams_oe_b));
`default_nettype wire

// file: verification/tsx_host_model.sv
`default_nettype none
module tsx_host_model (
	input wire core_clk,
	input wire ack_pin,
	input wire [15:0] data_pin,
	output logic host_cs_b,
	output logic host_strobe_n,
	output logic host_rd_wr,
	output logic [15:0] host_addr_bus,
	output logic [15:0] host_data_bus_i
);
	timeunit 1ns;
	timeprecision 1ns;
	logic tmo = 1'h0;
	// Idle bus at time zero
	initial begin
		host_cs_b = 1'h1;
		host_strobe_n = 1'h1;
		host_rd_wr = 1'h1;
		host_addr_bus = 16'h0000;
		host_data_bus_i = 16'hffff;
	end
	// One access, held until the acknowledge is seen low
	task automatic xfer(input logic rd, input logic [15:0] a, input logic [15:0] wd,
		input int slow, output logic [15:0] q);
		int n = 0;
		@(posedge core_clk);
		host_cs_b <= 1'h0;
		host_strobe_n <= 1'h0;
		host_rd_wr <= rd;
		host_addr_bus <= a;
		host_data_bus_i <= rd ? ~wd : wd;
		do begin
			@(posedge core_clk);
			n++;
		end while (ack_pin !== 1'h0 && n < 20);
		tmo = (ack_pin !== 1'h0);
		q = data_pin;
		repeat (slow) @(posedge core_clk);
		host_cs_b <= 1'h1;
		host_strobe_n <= 1'h1;
		host_data_bus_i <= ~host_data_bus_i;
		repeat (2) @(posedge core_clk);
	endtask
endmodule // tsx_host_model
`default_nettype wire

// file: verification/tdm_switch_host_and_pin_control_tb.sv
`default_nettype none
module tdm_switch_host_and_pin_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'h0;
	logic rst_b = 1'h1;
	logic sclk = 1'h0;
	logic fe = 1'h0;
	logic gate = 1'h0;
	logic cs_b, st_n, rw, ack_o, ack_oe_b, d_oe_b;
	logic [15:0] addr, wd, d_o, q;
	logic [31:0] so, so_oe_b;
	int mismatches = 0;
	int cmp_count = 0;
	logic [15:0] ra [5] = '{16'h4005, 16'h7fff, 16'h8003, 16'hc021, 16'hc000};
	logic [15:0] rv [5] = '{16'h8123, 16'h00a5, 16'h0001, 16'h0005, 16'h0000};
	// Pull-up on the acknowledge, inverse pattern on a floating data bus
	wire ack_pin = ack_oe_b ? 1'h1 : ack_o;
	wire [15:0] d_pin = d_oe_b ? ~wd : d_o;
	tsx_core u_dut (.core_clk(core_clk), .rst_b(rst_b), .serial_bit_clock_in(sclk),
		.frame_sync_in(1'h0), .frame_eval_in(fe), .output_drive_gate(gate),
		.host_cs_b(cs_b), .host_strobe_n(st_n), .host_rd_wr(rw), .host_addr_bus(addr),
		.host_data_bus_i(wd), .host_data_bus_o(d_o), .host_data_bus_oe_b(d_oe_b),
		.host_transfer_ack_o(ack_o), .host_transfer_ack_oe_b(ack_oe_b),
		.serial_in_streams(32'h0000_0000), .serial_out_streams_o(so),
		.serial_out_streams_oe_b(so_oe_b));
	tsx_host_model u_host (.core_clk(core_clk), .ack_pin(ack_pin), .data_pin(d_pin),
		.host_cs_b(cs_b), .host_strobe_n(st_n), .host_rd_wr(rw), .host_addr_bus(addr),
		.host_data_bus_i(wd));
	// Core clock, 40 ns
	initial forever #20 core_clk = ~core_clk;
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Access through the host model; reads end slowly
	task automatic acc(input logic r, input logic [15:0] a, input logic [15:0] v);
		u_host.xfer(r, a, v, int'(r), q);
		if (u_host.tmo) begin
			mismatches++;
			print_verdict();
		end
	endtask
	// Main sequence
	initial begin
		rst_b <= 1'h0;
		repeat (5) @(posedge core_clk);
		rst_b <= 1'h1;
		for (int i = 0; i < 5; i++) begin
			acc(1'h0, ra[i], rv[i]);
			acc(1'h1, ra[i], 16'h0000);
			chk("readback", {16'h0000, rv[i]}, {16'h0000, q});
		end
		acc(1'h0, 16'hc021, 16'h0007);
		rst_b <= 1'h0;
		@(posedge core_clk);
		chk("float", 32'hffff_ffff, so_oe_b);
		chk("hostfloat", 32'h0000_0003, {30'h0000_0000, d_oe_b, ack_oe_b});
		rst_b <= 1'h1;
		acc(1'h1, 16'hc021, 16'h0000);
		chk("offset", 32'h0000_0000, {16'h0000, q});
		for (int s = 0; s < 2; s++)
			for (int c = 0; c < 2; c++)
				acc(1'h0, {6'h10, s[0], 8'h00, c[0]}, s ? 16'h8000 : 16'h40a5);
		gate <= 1'h1;
		// Nine bit ticks; evaluation edge arrives on the sixth
		for (int k = 0; k < 18; k++) begin
			repeat (2) @(posedge core_clk);
			sclk <= ~sclk;
			if (k == 10) fe <= 1'h1;
		end
		repeat (2) @(posedge core_clk);
		chk("drive", 32'h0000_0002, {30'h0000_0000, so_oe_b[1:0]});
		chk("txbit", 32'h0000_0000, {31'h0000_0000, so[0]});
		gate <= 1'h0;
		repeat (2) @(posedge core_clk);
		chk("gate", 32'hffff_ffff, so_oe_b);
		acc(1'h1, 16'hc001, 16'h0000);
		chk("measure", 32'h0000_0005, {16'h0000, q});
		acc(1'h1, 16'hc002, 16'h0000);
		chk("format", 32'h0000_0003, {16'h0000, q});
		print_verdict();
	end
endmodule // tdm_switch_host_and_pin_control_tb
`default_nettype wire
